// ===== verilog/pmucsr_top.sv
// PMU control and status registers behind the serial slave port
`timescale 1ns/1ps
`include "pmucsr_params.svh"

module pmucsr_top #(
  parameter logic [6:0] DEV_ADDR = 7'h4a, // Slave address
  parameter logic [3:0] MASK_REV = 4'h1 // Arbitrary revision value
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_en,
  input wire logic i_over_temp,
  input wire logic i_cfg_sel,
  input wire logic i_seq_done,
  input wire logic [1:0] i_conv_light_load,
  input wire logic [1:0] i_conv_in_reg,
  input wire logic i_linreg1_in_reg,
  output pmucsr_pkg::pmucsr_conv_drv_t o_conv1_drv,
  output pmucsr_pkg::pmucsr_conv_drv_t o_conv2_drv,
  output logic o_conv_run,
  output logic [2:0] o_linreg_on,
  output logic [6:0] o_linreg_discharge,
  output logic o_power_good,
  output logic o_thermal_trip_flag
);

  // Register storage
  logic [7:0] conv1_out_q; // Limit in top bits, voltage code below
  logic [7:0] conv2_out_q;
  logic [7:0] conv_ctrl_q; // Discharge, fixed-frequency, hide bits
  logic [7:0] ldo_en_q; // LDO enables and first LDO hide bit
  logic [7:0] ldo_pd_q; // LDO pull-downs and restart policy

  // Unit sequencing
  pmucsr_pkg::pmucsr_unit_t unit_q;
  logic go_start; // Next cycle enters startup
  logic regs_clr; // Restore defaults on hot restart
  logic auto_restart;

  // Serial slave
  pmucsr_pkg::pmucsr_ser_t ser_q;
  logic scl_q; // Previous line samples for edge detection
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] shift_q; // Serial shift register
  logic [2:0] cnt_q; // Bit counter within a byte
  logic full_q; // Eight bits taken in
  logic rw_q; // Read transfer selected
  logic [7:0] ptr_q; // Register pointer, auto-increments
  logic ack_ok_q; // Master acknowledged last read byte
  logic drv_low_q; // Pull the data line low
  logic wr_stb; // One-cycle register write
  logic [7:0] rd_byte;
  logic [7:0] status_byte;

  // Control fields handed to the buck blocks
  pmucsr_pkg::pmucsr_conv_ctrl_t conv1_ctrl;
  pmucsr_pkg::pmucsr_conv_ctrl_t conv2_ctrl;

  // Register read multiplexer, used for every read byte
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input logic [7:0] st,
                                        input logic [7:0] r9,
                                        input logic [7:0] rb,
                                        input logic [7:0] rc,
                                        input logic [7:0] rd,
                                        input logic [7:0] re);
    case (a)
      `PMUCSR_ADDR_CONV1_OUT: rd_mux = r9;
      `PMUCSR_ADDR_CONV2_OUT: rd_mux = rb;
      `PMUCSR_ADDR_CONV_CTRL: rd_mux = rc;
      `PMUCSR_ADDR_LDO_EN: rd_mux = rd;
      `PMUCSR_ADDR_LDO_PD: rd_mux = re;
      `PMUCSR_ADDR_STATUS: rd_mux = st;
      default: rd_mux = 8'h00; // Unmapped reads as zero
    endcase
  endfunction

  // Line edges and bus conditions; lines are already synchronous
  assign scl_rise = i_scl & ~scl_q;
  assign scl_fall = ~i_scl & scl_q;
  assign start_cond = i_scl & scl_q & sda_q & ~i_sda;
  assign stop_cond = i_scl & scl_q & ~sda_q & i_sda;

  // Open-drain data line: only ever drives low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = drv_low_q;

  // Write lands when the eighth data bit is complete
  assign wr_stb = (ser_q == pmucsr_pkg::S_WDATA) & scl_fall & full_q;

  // Status: revision, out-of-regulation bits, thermal flag
  assign status_byte = {MASK_REV, // see [RQ13]
                        ~i_linreg1_in_reg, // see [RQ12]
                        ~i_conv_in_reg[1],
                        ~i_conv_in_reg[0],
                        unit_q == pmucsr_pkg::U_HOT}; // see [RQ11]

  assign rd_byte = rd_mux(ptr_q, status_byte, conv1_out_q, conv2_out_q,
                          conv_ctrl_q, ldo_en_q, ldo_pd_q);

  // Previous line samples
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // Serial slave state machine: address, pointer, data, acknowledge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ser_q <= pmucsr_pkg::S_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      rw_q <= 1'b0;
      ptr_q <= 8'h00;
      ack_ok_q <= 1'b0;
      drv_low_q <= 1'b0;
    end else if (start_cond) begin
      // Start or repeated start always restarts address phase
      ser_q <= pmucsr_pkg::S_DEVADR;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      drv_low_q <= 1'b0;
    end else if (stop_cond) begin
      ser_q <= pmucsr_pkg::S_IDLE;
      drv_low_q <= 1'b0;
    end else begin
      case (ser_q)
        pmucsr_pkg::S_IDLE: begin
          drv_low_q <= 1'b0;
        end
        pmucsr_pkg::S_DEVADR,
        pmucsr_pkg::S_REGADR,
        pmucsr_pkg::S_WDATA: begin
          // Take bits on the rising clock, act after the eighth
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], i_sda};
            cnt_q <= cnt_q + 3'h1;
            full_q <= (cnt_q == 3'h7);
          end else if (scl_fall && full_q) begin
            full_q <= 1'b0;
            if (ser_q == pmucsr_pkg::S_DEVADR) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                rw_q <= shift_q[0];
                drv_low_q <= 1'b1;
                ser_q <= pmucsr_pkg::S_ACKA;
              end else begin
                ser_q <= pmucsr_pkg::S_IDLE; // Not our address
              end
            end else if (ser_q == pmucsr_pkg::S_REGADR) begin
              ptr_q <= shift_q;
              drv_low_q <= 1'b1;
              ser_q <= pmucsr_pkg::S_ACKR;
            end else begin
              drv_low_q <= 1'b1;
              ser_q <= pmucsr_pkg::S_ACKW;
            end
          end
        end
        pmucsr_pkg::S_ACKA: begin
          // After address ack: send data or expect the pointer
          if (scl_fall) begin
            cnt_q <= 3'h0;
            if (rw_q) begin
              shift_q <= rd_byte;
              drv_low_q <= ~rd_byte[7];
              ser_q <= pmucsr_pkg::S_RDATA;
            end else begin
              drv_low_q <= 1'b0;
              ser_q <= pmucsr_pkg::S_REGADR;
            end
          end
        end
        pmucsr_pkg::S_ACKR: begin
          if (scl_fall) begin
            drv_low_q <= 1'b0;
            cnt_q <= 3'h0;
            ser_q <= pmucsr_pkg::S_WDATA;
          end
        end
        pmucsr_pkg::S_ACKW: begin
          // Pointer moves on so bursts fill consecutive registers
          if (scl_fall) begin
            drv_low_q <= 1'b0;
            ptr_q <= ptr_q + 8'h01;
            cnt_q <= 3'h0;
            ser_q <= pmucsr_pkg::S_WDATA;
          end
        end
        pmucsr_pkg::S_RDATA: begin
          // Shift out on falling clock; release for master ack
          if (scl_fall) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              drv_low_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              ser_q <= pmucsr_pkg::S_RACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              drv_low_q <= ~shift_q[6];
            end
          end
        end
        pmucsr_pkg::S_RACK: begin
          // Low data at the ack clock asks for another byte
          if (scl_rise) begin
            ack_ok_q <= ~i_sda;
          end else if (scl_fall) begin
            cnt_q <= 3'h0;
            if (ack_ok_q) begin
              shift_q <= rd_byte;
              drv_low_q <= ~rd_byte[7];
              ser_q <= pmucsr_pkg::S_RDATA;
            end else begin
              ser_q <= pmucsr_pkg::S_IDLE;
            end
          end
        end
        default: begin
          ser_q <= pmucsr_pkg::S_IDLE;
          drv_low_q <= 1'b0;
        end
      endcase
    end
  end

  // Writable registers; status address has no storage at all
  always_ff @(posedge i_clk) begin
    if (i_rst || regs_clr) begin // see [RQ10]
      conv1_out_q <= `PMUCSR_RST_CONV_OUT;
      conv2_out_q <= `PMUCSR_RST_CONV_OUT;
      conv_ctrl_q <= `PMUCSR_RST_CONV_CTRL;
      ldo_en_q <= `PMUCSR_RST_LDO_EN;
      ldo_pd_q <= `PMUCSR_RST_LDO_PD;
    end else if (wr_stb) begin
      // Writes to status or unmapped addresses fall through
      case (ptr_q)
        `PMUCSR_ADDR_CONV1_OUT: conv1_out_q <= shift_q;
        `PMUCSR_ADDR_CONV2_OUT: conv2_out_q <= shift_q;
        `PMUCSR_ADDR_CONV_CTRL: conv_ctrl_q <= shift_q;
        `PMUCSR_ADDR_LDO_EN: ldo_en_q <= shift_q;
        `PMUCSR_ADDR_LDO_PD: ldo_pd_q <= shift_q;
        default: ; // see [RQ14]
      endcase
    end
  end

  // Restart allowed by policy bit, or by the configuration input
  assign auto_restart = ldo_pd_q[`PMUCSR_B_RESTART] | i_cfg_sel;

  // Defaults return only when restart is not told to keep them
  assign regs_clr = (unit_q == pmucsr_pkg::U_HOT) & ~i_over_temp &
                    i_en & ~ldo_pd_q[`PMUCSR_B_RESTART] &
                    i_cfg_sel; // see [RQ9] see [RQ10]

  // Startup begins from idle on enable, or after cooling with auto restart
  assign go_start = ((unit_q == pmucsr_pkg::U_IDLE) & ~i_over_temp &
                     i_en) |
                    ((unit_q == pmucsr_pkg::U_HOT) & ~i_over_temp &
                     i_en & auto_restart); // see [RQ8]

  // Unit sequencing; over-temperature wins from every state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      unit_q <= pmucsr_pkg::U_IDLE;
    end else begin
      case (unit_q)
        pmucsr_pkg::U_IDLE: begin
          if (i_over_temp) begin
            unit_q <= pmucsr_pkg::U_HOT;
          end else if (go_start) begin
            unit_q <= pmucsr_pkg::U_START;
          end
        end
        pmucsr_pkg::U_START: begin
          if (i_over_temp) begin
            unit_q <= pmucsr_pkg::U_HOT;
          end else if (!i_en) begin
            unit_q <= pmucsr_pkg::U_IDLE;
          end else if (i_seq_done) begin
            unit_q <= pmucsr_pkg::U_RUN;
          end
        end
        pmucsr_pkg::U_RUN: begin
          if (i_over_temp) begin
            unit_q <= pmucsr_pkg::U_HOT;
          end else if (!i_en) begin
            unit_q <= pmucsr_pkg::U_IDLE;
          end
        end
        pmucsr_pkg::U_HOT: begin
          // Without auto restart, wait for enable to drop
          if (!i_over_temp) begin
            if (!i_en) begin
              unit_q <= pmucsr_pkg::U_IDLE;
            end else if (go_start) begin
              unit_q <= pmucsr_pkg::U_START; // see [RQ8]
            end
          end
        end
        default: begin
          unit_q <= pmucsr_pkg::U_IDLE;
        end
      endcase
    end
  end

  // Buck control fields gathered from the registers
  assign conv1_ctrl = '{
    limit_sel: conv1_out_q[`PMUCSR_CL_HI:`PMUCSR_CL_LO],
    force_fixed: conv_ctrl_q[`PMUCSR_B_CONV1_FIX],
    discharge: conv_ctrl_q[`PMUCSR_B_CONV1_PD],
    hide: conv_ctrl_q[`PMUCSR_B_CONV1_HIDE]};
  assign conv2_ctrl = '{
    limit_sel: conv2_out_q[`PMUCSR_CL_HI:`PMUCSR_CL_LO],
    force_fixed: conv_ctrl_q[`PMUCSR_B_CONV2_FIX],
    discharge: conv_ctrl_q[`PMUCSR_B_CONV2_PD],
    hide: conv_ctrl_q[`PMUCSR_B_CONV2_HIDE]};

  // First buck
  pmucsr_conv_ctrl u_conv1 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ctrl(conv1_ctrl),
    .i_run(o_conv_run),
    .i_light_load(i_conv_light_load[0]),
    .i_in_reg(i_conv_in_reg[0]),
    .o_drv(o_conv1_drv)
  );

  // Second buck
  pmucsr_conv_ctrl u_conv2 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ctrl(conv2_ctrl),
    .i_run(o_conv_run),
    .i_light_load(i_conv_light_load[1]),
    .i_in_reg(i_conv_in_reg[1]),
    .o_drv(o_conv2_drv)
  );

  // LDO enables: direct in idle, captured at startup entry
  pmucsr_linreg_ctrl u_linreg (
    .i_clk(i_clk),
    .i_rst(i_rst),
    // Defaults, not the old enables, are armed on a clearing restart
    .i_on_bits(ldo_en_q[`PMUCSR_B_LDO_EN_HI:`PMUCSR_B_LDO_EN_LO] &
               ~{3{regs_clr}}), // see [RQ10]
    .i_idle(unit_q == pmucsr_pkg::U_IDLE && !go_start),
    .i_armed(unit_q == pmucsr_pkg::U_START ||
             unit_q == pmucsr_pkg::U_RUN || go_start),
    .i_load(go_start),
    .o_on(o_linreg_on)
  );

  // Buck run, discharge, summary good flag and thermal flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_conv_run <= 1'b0;
      o_linreg_discharge <= 7'h00;
      o_power_good <= 1'b0;
      o_thermal_trip_flag <= 1'b0;
    end else begin
      o_conv_run <= (unit_q == pmucsr_pkg::U_START) ||
                    (unit_q == pmucsr_pkg::U_RUN);
      o_linreg_discharge <= ldo_pd_q[`PMUCSR_B_PD_HI:0]; // see [RQ15]
      // Hidden rails count as good; one cycle behind the bucks
      o_power_good <= o_conv1_drv.good_shown & o_conv2_drv.good_shown &
                      (ldo_en_q[`PMUCSR_B_LDO1_HIDE] |
                       i_linreg1_in_reg); // see [RQ5]
      o_thermal_trip_flag <= (unit_q == pmucsr_pkg::U_HOT); // see [RQ11]
    end
  end

endmodule

// ===== verilog/pmucsr_params.svh
// Register map, field positions, reset values and peak current limits
//
// Function
// [RQ1] Buck limit codes pick 460/780/1050/1370 mA
// [RQ2] Forced fixed-frequency bit keeps buck in PWM
// [RQ3] Cleared bit lets buck choose light-load automatically
// [RQ4] Buck hide bit suppresses its regulation-good indication
// [RQ5] First LDO hide bit suppresses its good indication
// [RQ6] Outside idle, LDO enable arms next startup
// [RQ7] In idle, LDO enable acts at once
// [RQ8] Restart bit decides auto startup after cooling
// [RQ9] Restart bit one keeps registers through shutdown
// [RQ10] Configuration one restores register defaults before restart
// [RQ11] Status bit zero shows thermal shutdown
// [RQ12] Status bits one to three show out-of-regulation
// [RQ13] Status bits seven to four hold revision
// [RQ14] Status register is read-only, writes ignored
// [RQ15] Pull-down bits enable output discharge when set
`ifndef PMUCSR_PARAMS_SVH
`define PMUCSR_PARAMS_SVH

// Register addresses
`define PMUCSR_ADDR_CONV1_OUT 8'h09
`define PMUCSR_ADDR_CONV2_OUT 8'h0b
`define PMUCSR_ADDR_CONV_CTRL 8'h0c
`define PMUCSR_ADDR_LDO_EN 8'h0d
`define PMUCSR_ADDR_LDO_PD 8'h0e
`define PMUCSR_ADDR_STATUS 8'h10

// Field positions, converter output registers
`define PMUCSR_CL_HI 7
`define PMUCSR_CL_LO 6
// Field positions, converter control register
`define PMUCSR_B_CONV1_PD 0
`define PMUCSR_B_CONV2_PD 1
`define PMUCSR_B_CONV1_FIX 2
`define PMUCSR_B_CONV2_FIX 3
`define PMUCSR_B_CONV1_HIDE 4
`define PMUCSR_B_CONV2_HIDE 5
// Field positions, LDO enable register
`define PMUCSR_B_LDO_EN_LO 1
`define PMUCSR_B_LDO_EN_HI 3
`define PMUCSR_B_LDO1_HIDE 7
// Field positions, LDO pull-down and thermal register
`define PMUCSR_B_PD_HI 6
`define PMUCSR_B_RESTART 7

// Reset values
`define PMUCSR_RST_CONV_OUT 8'h80
`define PMUCSR_RST_CONV_CTRL 8'h00
`define PMUCSR_RST_LDO_EN 8'h00
`define PMUCSR_RST_LDO_PD 8'h00

// Peak current limits in mA
`define PMUCSR_LIM_00 11'd460
`define PMUCSR_LIM_01 11'd780
`define PMUCSR_LIM_10 11'd1050
`define PMUCSR_LIM_11 11'd1370

`endif

// ===== verilog/pmucsr_pkg.sv
// Types shared by the PMU register bank modules
package pmucsr_pkg;

  // Power unit sequencing state, one-hot
  typedef enum logic [3:0] {
    U_IDLE  = 4'h1,
    U_START = 4'h2,
    U_RUN   = 4'h4,
    U_HOT   = 4'h8
  } pmucsr_unit_t;

  // Serial slave state, one-hot
  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_DEVADR = 9'h002,
    S_ACKA   = 9'h004,
    S_REGADR = 9'h008,
    S_ACKR   = 9'h010,
    S_WDATA  = 9'h020,
    S_ACKW   = 9'h040,
    S_RDATA  = 9'h080,
    S_RACK   = 9'h100
  } pmucsr_ser_t;

  // Software control of one buck
  typedef struct packed {
    logic [1:0] limit_sel;
    logic force_fixed;
    logic discharge;
    logic hide;
  } pmucsr_conv_ctrl_t;

  // Drive of one buck toward the analog side
  typedef struct packed {
    logic [10:0] peak_ma;
    logic pwm_mode;
    logic light_load_mode;
    logic discharge;
    logic good_shown;
  } pmucsr_conv_drv_t;

endpackage

// ===== verilog/pmucsr_conv_ctrl.sv
// Per-buck mode, current limit, discharge and good-flag logic
`timescale 1ns/1ps
`include "pmucsr_params.svh"

module pmucsr_conv_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire pmucsr_pkg::pmucsr_conv_ctrl_t i_ctrl,
  input wire logic i_run,
  input wire logic i_light_load,
  input wire logic i_in_reg,
  output pmucsr_pkg::pmucsr_conv_drv_t o_drv
);

  // Code to peak limit in mA
  function automatic logic [10:0] lim_ma(input logic [1:0] code);
    case (code)
      2'h0: lim_ma = `PMUCSR_LIM_00;
      2'h1: lim_ma = `PMUCSR_LIM_01;
      2'h2: lim_ma = `PMUCSR_LIM_10;
      default: lim_ma = `PMUCSR_LIM_11;
    endcase
  endfunction

  // All outputs registered so the analog side sees clean levels
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Limit shows the reset code's figure, never an undecoded zero
      o_drv <= '{peak_ma: `PMUCSR_LIM_10, default: 1'b0};
    end else begin
      o_drv.peak_ma <= lim_ma(i_ctrl.limit_sel); // see [RQ1]
      // Forced bit blocks light-load, else follow the load detector
      o_drv.light_load_mode <= i_run & ~i_ctrl.force_fixed &
                               i_light_load; // see [RQ2] see [RQ3]
      o_drv.pwm_mode <= i_run & (i_ctrl.force_fixed |
                                 ~i_light_load); // see [RQ2] see [RQ3]
      o_drv.discharge <= i_ctrl.discharge; // see [RQ15]
      // Hidden flag reads as good so it cannot pull the summary low
      o_drv.good_shown <= i_ctrl.hide | i_in_reg; // see [RQ4]
    end
  end

endmodule

// ===== verilog/pmucsr_linreg_ctrl.sv
// Applies LDO enable bits, at once in idle or armed for startup
`timescale 1ns/1ps

module pmucsr_linreg_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_on_bits,
  input wire logic i_idle,
  input wire logic i_armed,
  input wire logic i_load,
  output logic [2:0] o_on
);

  logic [2:0] seq_q; // Enables captured at startup entry

  // Capture the programmed set when a startup begins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seq_q <= 3'h0;
    end else if (i_load) begin
      seq_q <= i_on_bits; // see [RQ6]
    end
  end

  // Idle follows the bits, sequencing uses the captured copy
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_on <= 3'h0;
    end else if (i_idle) begin
      o_on <= i_on_bits; // see [RQ7]
    end else if (i_armed) begin
      o_on <= i_load ? i_on_bits : seq_q; // see [RQ6]
    end else begin
      o_on <= 3'h0; // Thermal shutdown forces all off
    end
  end

endmodule

// ===== verification/pmucsr_chk_sva.sv
// Pin-level assertions for the PMU register bank
`timescale 1ns/1ps
module pmucsr_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_over_temp,
  input wire logic [1:0] i_conv_in_reg,
  input wire pmucsr_pkg::pmucsr_conv_drv_t o_conv1_drv,
  input wire logic o_sda_oe,
  input wire logic o_conv_run,
  input wire logic [2:0] o_linreg_on,
  input wire logic o_thermal_trip_flag
);
  // One clock domain, so one clock and one reset serve every check
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Limit is always one of the four decoded figures
  peak_legal_a: assert property (
    o_conv1_drv.peak_ma inside {11'h1cc, 11'h30c, 11'h41a, 11'h55a})
    else $error("buck peak limit outside the decoded set");
  // Fixed-frequency and light-load never together
  mode_excl_a: assert property (
    !(o_conv1_drv.pwm_mode && o_conv1_drv.light_load_mode))
    else $error("both switching modes at once");
  // A stopped buck shows no switching mode
  stop_mode_a: assert property (
    !o_conv_run [*3] |-> !o_conv1_drv.pwm_mode
    && !o_conv1_drv.light_load_mode)
    else $error("switching mode while stopped");
  // A rail in regulation is never hidden as bad
  good_pass_a: assert property (
    i_conv_in_reg[0] [*3] |-> o_conv1_drv.good_shown)
    else $error("good indication lost");
  // Over-temperature reaches the trip flag quickly
  trip_follow_a: assert property (
    i_over_temp |-> ##[1:3] o_thermal_trip_flag)
    else $error("trip flag late");
  // Trip flag only rises after a hot sensor
  trip_cause_a: assert property (
    $rose(o_thermal_trip_flag) |-> $past(i_over_temp)
    || $past(i_over_temp, 2))
    else $error("trip flag without heat");
  // Shutdown stops the bucks
  hot_stop_a: assert property (
    !(o_thermal_trip_flag && o_conv_run))
    else $error("bucks run in shutdown");
  // Enable writes while running wait for the next startup
  run_hold_a: assert property (
    o_conv_run [*4] |-> $stable(o_linreg_on))
    else $error("linear regulator changed while running");
  // Data line only moves while the serial clock is low
  ack_edge_a: assert property (
    $changed(o_sda_oe) |-> !$past(i_scl))
    else $error("data drive moved with clock high");
endmodule

bind pmucsr_top pmucsr_chk chk_u (
  .i_clk, .i_rst, .i_scl, .i_over_temp, .i_conv_in_reg, .o_conv1_drv,
  .o_sda_oe, .o_conv_run, .o_linreg_on, .o_thermal_trip_flag
);

// ===== verification/pmucsr_host.sv
// Serial host model that drives the register port
`timescale 1ns/1ps
module pmucsr_host #(
  parameter logic [6:0] ADDR = 7'h4a // Slave address used
) (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  int ph = 2; // Phase length in clocks; the bench stretches it
  // Idle bus: both lines released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Lines move at falling edges, away from the device's sampling
  task automatic gap(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Start, also a repeated start from a low clock phase
  task automatic start();
    o_sda_low = 1'b0;
    gap(ph);
    o_scl = 1'b1;
    gap(ph);
    o_sda_low = 1'b1;
    gap(ph);
    o_scl = 1'b0;
    gap(1);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    gap(ph);
    o_scl = 1'b1;
    gap(ph);
    o_sda_low = 1'b0;
    gap(ph);
  endtask
  // One bit: set in the low phase, sampled late in the high one
  task automatic bit_x(input logic b, output logic r);
    o_sda_low = ~b;
    gap(ph);
    o_scl = 1'b1;
    gap(ph);
    r = i_sda;
    o_scl = 1'b0;
    gap(1);
  endtask
  // Byte out, MSB first; ack is high when the device took it
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Byte in, then not-acknowledge to end the read
  task automatic get(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(1'b1, r);
  endtask
  // Register write; the status place is written only to probe refusal
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic k1, k2, k3;
    start();
    put({ADDR, 1'b0}, k1);
    put(a, k2);
    put(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    put({ADDR, 1'b0}, k);
    put(a, k);
    start();
    put({ADDR, 1'b1}, k);
    get(d);
    stop();
  endtask
endmodule

// ===== verification/test_pmu_control_status_regs.sv
// Self-checking bench for the PMU register bank
`timescale 1ns/1ps
module test_pmu_control_status_regs;
  localparam logic [3:0] REV = 4'h6; // Arbitrary revision value
  logic i_clk, i_rst, scl, sda_low, en, ot, cfg, sdone, l1, ack;
  logic oe, sda_o, run, pg, trip;
  logic [1:0] ll, inr;
  logic [2:0] on;
  logic [6:0] dis, x;
  logic [7:0] v, w;
  pmucsr_pkg::pmucsr_conv_drv_t c1, c2;
  int errors = 0;
  int num_checks = 0;
  int seed = 32'hfb44;
  wire sda = ~(sda_low | oe); // Pull-up unless someone pulls low

  pmucsr_top #(.DEV_ADDR(7'h4a), .MASK_REV(REV)) dut_u (
    .i_clk, .i_rst, .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(oe), .i_en(en), .i_over_temp(ot), .i_cfg_sel(cfg),
    .i_seq_done(sdone), .i_conv_light_load(ll), .i_conv_in_reg(inr),
    .i_linreg1_in_reg(l1), .o_conv1_drv(c1), .o_conv2_drv(c2),
    .o_conv_run(run), .o_linreg_on(on), .o_linreg_discharge(dis),
    .o_power_good(pg), .o_thermal_trip_flag(trip));
  pmucsr_host #(.ADDR(7'h4a)) host_u (
    .i_clk, .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  always #2 i_clk = ~i_clk;

  // Decoded peak limit in mA for a code
  function automatic logic [10:0] lim(input logic [1:0] c);
    case (c)
      2'h0: lim = 11'h1cc;
      2'h1: lim = 11'h30c;
      2'h2: lim = 11'h41a;
      default: lim = 11'h55a;
    endcase
  endfunction
  // Running buck: pwm, light-load, discharge, good shown
  function automatic logic [3:0] mode(input logic [7:0] c,
      input logic l, input logic g, input int k);
    mode = {c[2+k] | ~l, ~c[2+k] & l, c[k], g | c[4+k]};
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Register write; every mapped or not, the device acknowledges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host_u.wr(a, d, ok);
    chk(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask

  // Cuts a hang short well past the expected run length
  initial begin
    wait_n(80000);
    errors++;
    report_and_stop();
  end

  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    {en, ot, cfg, sdone, ll} = 6'h00;
    {inr, l1} = 3'h7;
    wait_n(12);
    i_rst = 1'b0;
    wait_n(2);
    chk(c1.peak_ma, 11'h41a);
    chk(c2.peak_ma, 11'h41a);
    rd(8'h10, {REV, 4'h0});
    // Every limit code on both bucks, spare bits random
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], 6'($random(seed))};
      wr(i[2] ? 8'h0b : 8'h09, v);
      wait_n(3);
      chk(i[2] ? c2.peak_ma : c1.peak_ma, lim(i[1:0]));
      rd(i[2] ? 8'h0b : 8'h09, v);
    end
    en = 1'b1;
    sdone = 1'b1;
    wait_n(4);
    // Modes, discharge and hiding under random loads, first all clear
    for (int i = 0; i < 10; i++) begin
      v = i < 2 ? {8{i[0]}} : 8'($random(seed));
      {ll, inr, l1} = 5'($random(seed));
      wr(8'h0c, v);
      wait_n(4);
      chk(c1[3:0], mode(v, ll[0], inr[0], 0));
      chk(c2[3:0], mode(v, ll[1], inr[1], 1));
      chk(pg, (inr[0] | v[4]) & (inr[1] | v[5]) & l1);
      rd(8'h0c, v);
      rd(8'h10, {REV, ~l1, ~inr, 1'b0});
      wr(8'h10, ~v);
      rd(8'h10, {REV, ~l1, ~inr, 1'b0});
    end
    // Linear enables: at once in idle, otherwise at the next startup
    host_u.ph = 4;
    {inr, l1} = 3'h6;
    for (int i = 0; i < 6; i++) begin
      en = 1'b0;
      w = 8'($random(seed));
      wr(8'h0d, w);
      wait_n(3);
      chk(on, w[3:1]);
      chk(pg, w[7]);
      sdone = 1'b0;
      en = 1'b1;
      wait_n(3);
      v = 8'($random(seed));
      wr(8'h0d, v);
      sdone = 1'b1;
      wait_n(3);
      chk(on, w[3:1]);
      en = 1'b0;
      wait_n(3);
      chk(on, v[3:1]);
      en = 1'b1;
      wait_n(4);
      chk(on, v[3:1]);
    end
    host_u.ph = 2;
    l1 = 1'b1;
    // Shutdown with the keep policy, then restart
    x = 7'($random(seed));
    wr(8'h0e, {1'b1, x});
    wait_n(3);
    chk(dis, x);
    ot = 1'b1;
    wait_n(4);
    chk({trip, run, on}, 5'h10);
    rd(8'h10, {REV, 4'h1});
    ot = 1'b0;
    wait_n(6);
    chk({trip, run}, 2'h1);
    rd(8'h0e, {1'b1, x});
    // Policy clear with configuration set: defaults come back
    wr(8'h0e, {1'b0, x});
    cfg = 1'b1;
    ot = 1'b1;
    wait_n(4);
    ot = 1'b0;
    wait_n(6);
    chk({trip, run, on, dis}, 12'h400);
    rd(8'h09, 8'h80);
    // Neither set: the unit stays down after cooling
    cfg = 1'b0;
    ot = 1'b1;
    wait_n(4);
    ot = 1'b0;
    wait_n(6);
    chk({trip, run}, 2'h2);
    en = 1'b0;
    wait_n(4);
    chk(trip, 1'b0);
    // Unknown slave address is not acknowledged
    host_u.start();
    host_u.put(8'h26, ack);
    host_u.stop();
    chk(ack, 1'b0);
    chk(sda_o, 1'b0);
    // Unmapped place: write dropped, read gives zero
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    report_and_stop();
  end
endmodule
